// [verilog/lce_regs.svh]
// Purpose: register map, field positions, reset values and timing counts of the lens correction control shell
// Assumes: byte addresses on a 32-bit register bus, one aligned word per register
// Notes: definitions only
`ifndef LCE_REGS_SVH
`define LCE_REGS_SVH

// register byte offsets
`define LCE_OFS_CTRL 7'h00
`define LCE_OFS_FRAME_SIZE 7'h04
`define LCE_OFS_SRC_BASE 7'h08
`define LCE_OFS_SRC_PITCH 7'h0C
`define LCE_OFS_DST_BASE 7'h10
`define LCE_OFS_DST_PITCH 7'h14
`define LCE_OFS_CHROMA_SRC 7'h18
`define LCE_OFS_CHROMA_DST 7'h1C
`define LCE_OFS_BLOCK 7'h20
`define LCE_OFS_REGION_XY 7'h24
`define LCE_OFS_REGION_WH 7'h28
`define LCE_OFS_REGION_BASE 7'h2C
`define LCE_OFS_TBL_PTR 7'h30
`define LCE_OFS_TBL_WDATA 7'h34
`define LCE_OFS_TBL_RDATA 7'h38
`define LCE_OFS_STATUS 7'h3C

// control and status register bit positions
`define LCE_CTRL_RUN 0
`define LCE_CTRL_BUSY 1
`define LCE_CTRL_FUNC_LO 2
`define LCE_CTRL_ROUTE 8
`define LCE_CTRL_OWNER 9
`define LCE_CTRL_GATE 10
`define LCE_STATUS_BUSY 16

// reset values of control fields
`define LCE_RST_FUNC 2'h0
`define LCE_RST_ROUTE 1'h0
`define LCE_RST_OWNER 1'h1
`define LCE_RST_GATE 1'h1

// table geometry
`define LCE_TBL_DEPTH 768
`define LCE_TBL_LAST 10'h2FF

// timing: one output block takes a fixed processing time
`define LCE_CLK_PERIOD_NS 10
`define LCE_BLOCK_TIME_NS 160
`define LCE_BLOCK_CYCLES ((`LCE_BLOCK_TIME_NS + `LCE_CLK_PERIOD_NS - 1) / `LCE_CLK_PERIOD_NS)
`define LCE_PIX_BYTES 32'h0000_0002

`endif

// [verilog/lce_pkg.sv]
// Purpose: types shared by the lens correction control shell
// Assumes: widths fixed by the register layout
// Notes: numbers live in lce_regs.svh
package lce_pkg;

  typedef enum logic [1:0] {
    LCE_IDLE = 2'b00,
    LCE_RUN = 2'b01,
    LCE_DONE = 2'b10
  } lce_phase_t;

  typedef struct packed {
    logic wait_rq;
    logic [31:0] rdata;
    logic [1:0] func_sel;
    logic route_sel;
    logic owner_sel;
    logic clk_gate;
    logic [12:0] frame_w;
    logic [12:0] frame_h;
    logic [31:0] src_base;
    logic [31:0] src_pitch;
    logic [31:0] dst_base;
    logic [31:0] dst_pitch;
    logic [31:0] chroma_src;
    logic [31:0] chroma_dst;
    logic [7:0] blk_w;
    logic [7:0] blk_h;
    logic [12:0] org_x;
    logic [12:0] org_y;
    logic [12:0] reg_w;
    logic [12:0] reg_h;
    logic [31:0] reg_base;
    logic [9:0] tbl_ptr;
    logic busy;
    lce_phase_t phase;
    logic [7:0] cyc;
    logic [13:0] off_x;
    logic [13:0] off_y;
    logic [31:0] row_addr;
    logic [31:0] col_off;
    logic [15:0] blk_cnt;
    logic eof;
    logic bv;
    logic [31:0] baddr;
    logic [13:0] bx;
    logic [13:0] by;
  } lce_state_t;

  typedef struct packed {
    logic [15:0] rdata;
  } lce_ram_state_t;

endpackage

// [verilog/lce_tbl_if.sv]
// Purpose: carrier between the control shell and its look-up table memory
// Assumes: both ends on ref_clk
// Notes: the register-port path and the processor path share one memory
`timescale 1ns/1ps
interface lce_tbl_if;
  logic owner_eng;
  logic reg_we;
  logic [9:0] reg_addr;
  logic [15:0] reg_wdata;
  logic cpu_req;
  logic cpu_we;
  logic [9:0] cpu_addr;
  logic [15:0] cpu_wdata;
  logic [15:0] rdata;
  modport ctrl (output owner_eng, reg_we, reg_addr, reg_wdata, cpu_req, cpu_we, cpu_addr, cpu_wdata,
                input rdata);
  modport ram (input owner_eng, reg_we, reg_addr, reg_wdata, cpu_req, cpu_we, cpu_addr, cpu_wdata,
               output rdata);
endinterface

// [verilog/lce_table_ram.sv]
// Purpose: look-up table memory with a selectable owner
// Assumes: processor path inputs are on ref_clk
// Notes: the array has no reset, so contents survive a module reset
`timescale 1ns/1ps
`include "lce_regs.svh"
module lce_table_ram
  import lce_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  lce_tbl_if.ram tb
);

  logic [15:0] mem [0:`LCE_TBL_DEPTH-1];
  lce_ram_state_t s;
  lce_ram_state_t next_s;
  logic [9:0] addr;
  logic we;
  logic [15:0] wdata;

  //////////////////////////////////////////////////////////////////////////////
  // owner select picks the path; the other path is simply ignored
  always_comb begin
    addr = tb.owner_eng ? tb.reg_addr : tb.cpu_addr;
    we = tb.owner_eng ? tb.reg_we : (tb.cpu_req & tb.cpu_we);
    wdata = tb.owner_eng ? tb.reg_wdata : tb.cpu_wdata;
    next_s = s;
    next_s.rdata = (addr < 10'(`LCE_TBL_DEPTH)) ? mem[addr] : 16'h0000;
  end

  // memory array: no reset branch on purpose, power-on contents unknown
  always_ff @(posedge ref_clk) begin
    if (we && (addr < 10'(`LCE_TBL_DEPTH))) begin
      mem[addr] <= wdata;
    end
  end

  // registered read of the addressed entry
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tb.rdata = s.rdata;

endmodule

// [verilog/lce_ctrl_top.sv]
// Purpose: control shell of the lens correction engine: registers, table access and frame run sequencing
// Assumes: Avalon-MM slave with waitrequest, byte addresses, single clock ref_clk at 100 MHz
// Notes: correction arithmetic is outside; the run walks output blocks of one region and reports them
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "lce_regs.svh"
module lce_ctrl_top
  import lce_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_tbl_req,
  input wire logic cpu_tbl_we,
  input wire logic [9:0] cpu_tbl_addr,
  input wire logic [15:0] cpu_tbl_wdata,
  output logic [15:0] cpu_tbl_rdata,
  output logic eng_busy,
  output logic frame_done_evt,
  output logic [1:0] func_select,
  output logic out_route_select,
  output logic blk_wr_valid,
  output logic [31:0] blk_wr_addr,
  output logic [13:0] blk_x,
  output logic [13:0] blk_y
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] lce_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // table pointer step, wrapping after the last entry
  function automatic logic [9:0] lce_ptr_inc(input logic [9:0] p);
    return (p == `LCE_TBL_LAST) ? 10'h000 : p + 10'h001;
  endfunction

  lce_state_t s;
  lce_state_t next_s;
  logic take_wr;
  logic take_rd;
  logic wr_ok;
  logic start_go;
  logic no_blocks;
  logic last_col;
  logic last_row;
  logic [31:0] ctrl_word;
  logic [31:0] m;
  logic tbl_we;

  lce_tbl_if tbl_bus();

  // every assertion below runs on ref_clk and rests during reset
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  //////////////////////////////////////////////////////////////////////////////
  // table memory

  assign tbl_bus.owner_eng = s.owner_sel;
  assign tbl_bus.reg_we = tbl_we;
  assign tbl_bus.reg_addr = s.tbl_ptr;
  assign tbl_bus.reg_wdata = avs_writedata[15:0];
  assign tbl_bus.cpu_req = cpu_tbl_req;
  assign tbl_bus.cpu_we = cpu_tbl_we;
  assign tbl_bus.cpu_addr = cpu_tbl_addr;
  assign tbl_bus.cpu_wdata = cpu_tbl_wdata;

  lce_table_ram lce_table_ram_inst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tb(tbl_bus.ram)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic: bus slave, register file, run sequencer
  always_comb begin
    next_s = s;
    next_s.eof = 1'b0;
    next_s.bv = 1'b0;
    // one wait cycle per request, answer on the cycle after
    take_wr = avs_write && !s.wait_rq;
    take_rd = avs_read && !s.wait_rq;
    wr_ok = take_wr && !s.busy;
    next_s.wait_rq = !((avs_read || avs_write) && s.wait_rq);
    ctrl_word = '0;
    ctrl_word[`LCE_CTRL_RUN] = s.busy;
    ctrl_word[`LCE_CTRL_BUSY] = s.busy;
    ctrl_word[`LCE_CTRL_FUNC_LO +: 2] = s.func_sel;
    ctrl_word[`LCE_CTRL_ROUTE] = s.route_sel;
    ctrl_word[`LCE_CTRL_OWNER] = s.owner_sel;
    ctrl_word[`LCE_CTRL_GATE] = s.clk_gate;
    m = lce_merge(32'h0000_0000, avs_writedata, avs_byteenable);
    start_go = 1'b0;
    tbl_we = 1'b0;
    no_blocks = (s.blk_w == 8'h00) || (s.blk_h == 8'h00) || (s.reg_w == 13'h0000) || (s.reg_h == 13'h0000);
    last_col = ({6'h00, s.blk_w} + s.off_x) >= {1'b0, s.reg_w};
    last_row = ({6'h00, s.blk_h} + s.off_y) >= {1'b0, s.reg_h};

    // read data is latched in the wait cycle so it stands at the taking edge
    if (avs_read && s.wait_rq) begin
      case (avs_address)
        `LCE_OFS_CTRL: next_s.rdata = ctrl_word;
        `LCE_OFS_FRAME_SIZE: next_s.rdata = {3'h0, s.frame_h, 3'h0, s.frame_w};
        `LCE_OFS_SRC_BASE: next_s.rdata = s.src_base;
        `LCE_OFS_SRC_PITCH: next_s.rdata = s.src_pitch;
        `LCE_OFS_DST_BASE: next_s.rdata = s.dst_base;
        `LCE_OFS_DST_PITCH: next_s.rdata = s.dst_pitch;
        `LCE_OFS_CHROMA_SRC: next_s.rdata = s.chroma_src;
        `LCE_OFS_CHROMA_DST: next_s.rdata = s.chroma_dst;
        `LCE_OFS_BLOCK: next_s.rdata = {8'h00, s.blk_h, 8'h00, s.blk_w};
        `LCE_OFS_REGION_XY: next_s.rdata = {3'h0, s.org_y, 3'h0, s.org_x};
        `LCE_OFS_REGION_WH: next_s.rdata = {3'h0, s.reg_h, 3'h0, s.reg_w};
        `LCE_OFS_REGION_BASE: next_s.rdata = s.reg_base;
        `LCE_OFS_TBL_PTR: next_s.rdata = {22'h000000, s.tbl_ptr};
        `LCE_OFS_TBL_RDATA: next_s.rdata = {16'h0000, tbl_bus.rdata};
        `LCE_OFS_STATUS: next_s.rdata = {15'h0000, s.busy, s.blk_cnt};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // register writes; a busy engine accepts and drops them
    if (wr_ok) begin
      case (avs_address)
        `LCE_OFS_CTRL: begin
          m = lce_merge(ctrl_word, avs_writedata, avs_byteenable);
          next_s.func_sel = m[`LCE_CTRL_FUNC_LO +: 2];
          next_s.route_sel = m[`LCE_CTRL_ROUTE];
          next_s.owner_sel = m[`LCE_CTRL_OWNER];
          next_s.clk_gate = m[`LCE_CTRL_GATE];
          // with the engine clock gated off a start would hang, so it is dropped
          start_go = avs_byteenable[0] && avs_writedata[`LCE_CTRL_RUN] && m[`LCE_CTRL_GATE];
        end
        `LCE_OFS_FRAME_SIZE: begin
          m = lce_merge({3'h0, s.frame_h, 3'h0, s.frame_w}, avs_writedata, avs_byteenable);
          next_s.frame_w = m[12:0];
          next_s.frame_h = m[28:16];
        end
        `LCE_OFS_SRC_BASE: next_s.src_base = lce_merge(s.src_base, avs_writedata, avs_byteenable);
        `LCE_OFS_SRC_PITCH: next_s.src_pitch = lce_merge(s.src_pitch, avs_writedata, avs_byteenable);
        `LCE_OFS_DST_BASE: next_s.dst_base = lce_merge(s.dst_base, avs_writedata, avs_byteenable);
        `LCE_OFS_DST_PITCH: next_s.dst_pitch = lce_merge(s.dst_pitch, avs_writedata, avs_byteenable);
        `LCE_OFS_CHROMA_SRC: next_s.chroma_src = lce_merge(s.chroma_src, avs_writedata, avs_byteenable);
        `LCE_OFS_CHROMA_DST: next_s.chroma_dst = lce_merge(s.chroma_dst, avs_writedata, avs_byteenable);
        `LCE_OFS_BLOCK: begin
          m = lce_merge({8'h00, s.blk_h, 8'h00, s.blk_w}, avs_writedata, avs_byteenable);
          next_s.blk_w = m[7:0];
          next_s.blk_h = m[23:16];
        end
        `LCE_OFS_REGION_XY: begin
          m = lce_merge({3'h0, s.org_y, 3'h0, s.org_x}, avs_writedata, avs_byteenable);
          next_s.org_x = m[12:0];
          next_s.org_y = m[28:16];
        end
        `LCE_OFS_REGION_WH: begin
          m = lce_merge({3'h0, s.reg_h, 3'h0, s.reg_w}, avs_writedata, avs_byteenable);
          next_s.reg_w = m[12:0];
          next_s.reg_h = m[28:16];
        end
        `LCE_OFS_REGION_BASE: next_s.reg_base = lce_merge(s.reg_base, avs_writedata, avs_byteenable);
        `LCE_OFS_TBL_PTR: begin
          m = lce_merge({22'h000000, s.tbl_ptr}, avs_writedata, avs_byteenable);
          next_s.tbl_ptr = m[9:0];
        end
        `LCE_OFS_TBL_WDATA: begin
          if (s.owner_sel) begin
            tbl_we = 1'b1;
            next_s.tbl_ptr = lce_ptr_inc(s.tbl_ptr);
          end
        end
        default: next_s.rdata = s.rdata;
      endcase
    end

    // a register-port read of the table also steps the pointer
    if (take_rd && (avs_address == `LCE_OFS_TBL_RDATA) && s.owner_sel) begin
      next_s.tbl_ptr = lce_ptr_inc(s.tbl_ptr);
    end

    // run sequencer: one frame per start, no way to abort
    case (s.phase)
      LCE_IDLE: begin
        if (start_go) begin
          next_s.busy = 1'b1;
          next_s.off_x = 14'h0000;
          next_s.off_y = 14'h0000;
          next_s.row_addr = s.reg_base;
          next_s.col_off = 32'h0000_0000;
          next_s.blk_cnt = 16'h0000;
          next_s.cyc = 8'h00;
          next_s.phase = no_blocks ? LCE_DONE : LCE_RUN;
        end
      end
      LCE_RUN: begin
        if (s.cyc == 8'(`LCE_BLOCK_CYCLES - 1)) begin
          // only blocks inside the region are issued
          next_s.bv = 1'b1;
          next_s.baddr = s.row_addr + s.col_off;
          next_s.bx = {1'b0, s.org_x} + s.off_x;
          next_s.by = {1'b0, s.org_y} + s.off_y;
          next_s.blk_cnt = s.blk_cnt + 16'h0001;
          next_s.cyc = 8'h00;
          if (last_col) begin
            next_s.off_x = 14'h0000;
            next_s.col_off = 32'h0000_0000;
            if (last_row) begin
              next_s.phase = LCE_DONE;
            end else begin
              next_s.off_y = s.off_y + {6'h00, s.blk_h};
              next_s.row_addr = s.row_addr + 32'(s.dst_pitch * {24'h000000, s.blk_h});
            end
          end else begin
            next_s.off_x = s.off_x + {6'h00, s.blk_w};
            next_s.col_off = s.col_off + 32'({24'h000000, s.blk_w} * `LCE_PIX_BYTES);
          end
        end else begin
          next_s.cyc = s.cyc + 8'h01;
        end
      end
      LCE_DONE: begin
        next_s.eof = 1'b1;
        next_s.busy = 1'b0;
        next_s.phase = LCE_IDLE;
      end
      default: begin
        next_s.phase = LCE_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register; reset brings every control field to its reset value
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.wait_rq <= 1'b1;
      s.func_sel <= `LCE_RST_FUNC;
      s.route_sel <= `LCE_RST_ROUTE;
      s.owner_sel <= `LCE_RST_OWNER;
      s.clk_gate <= `LCE_RST_GATE;
      s.phase <= LCE_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register, except cpu_tbl_rdata, which comes from the table memory's read register
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.wait_rq;
  assign cpu_tbl_rdata = tbl_bus.rdata;
  assign eng_busy = s.busy;
  assign frame_done_evt = s.eof;
  assign func_select = s.func_sel;
  assign out_route_select = s.route_sel;
  assign blk_wr_valid = s.bv;
  assign blk_wr_addr = s.baddr;
  assign blk_x = s.bx;
  assign blk_y = s.by;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_start_busy;
    start_go && !s.busy |=> eng_busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("run start did not set busy");

  property p_lock;
    take_wr && s.busy && (avs_address == `LCE_OFS_SRC_BASE) |=> $stable(s.src_base) && avs_waitrequest;
  endproperty
  a_lock: assert property (p_lock) else $error("write while busy changed a register");

  property p_unlock;
    take_wr && !s.busy && (avs_address == `LCE_OFS_DST_BASE) && (avs_byteenable == 4'hF)
      |=> s.dst_base == $past(avs_writedata);
  endproperty
  a_unlock: assert property (p_unlock) else $error("write while idle was not stored");

  property p_ptr_wr;
    wr_ok && (avs_address == `LCE_OFS_TBL_WDATA) && s.owner_sel |=> s.tbl_ptr == lce_ptr_inc($past(s.tbl_ptr));
  endproperty
  a_ptr_wr: assert property (p_ptr_wr) else $error("table write did not step pointer");

  property p_ptr_rd;
    take_rd && (avs_address == `LCE_OFS_TBL_RDATA) && s.owner_sel |=> s.tbl_ptr == lce_ptr_inc($past(s.tbl_ptr));
  endproperty
  a_ptr_rd: assert property (p_ptr_rd) else $error("table read did not step pointer");

  property p_cpu_owner;
    (take_wr || take_rd) && !s.owner_sel && (avs_address inside {`LCE_OFS_TBL_WDATA, `LCE_OFS_TBL_RDATA})
      |-> !tbl_we ##1 $stable(s.tbl_ptr);
  endproperty
  a_cpu_owner: assert property (p_cpu_owner) else $error("register port used table it does not own");

  property p_eof_end;
    frame_done_evt |-> !eng_busy && $past(eng_busy);
  endproperty
  a_eof_end: assert property (p_eof_end) else $error("end event without busy falling");

  property p_self_clear;
    $fell(eng_busy) |-> frame_done_evt;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("busy cleared without end event");

  property p_one_shot;
    !s.busy && !start_go |=> !s.busy;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("engine ran without a start");

  property p_in_region;
    blk_wr_valid |-> (blk_x < ({1'b0, s.org_x} + {1'b0, s.reg_w})) && (blk_y < ({1'b0, s.org_y} + {1'b0, s.reg_h}));
  endproperty
  a_in_region: assert property (p_in_region) else $error("block issued outside region");

  c_run: cover property (start_go ##[1:300] frame_done_evt);
  c_locked: cover property (take_wr && s.busy);
  c_tbl_wr: cover property (tbl_we ##[1:20] tbl_we);
  c_block: cover property (blk_wr_valid);

endmodule

// [verif/lce_sdram_model.sv]
// Purpose: SDRAM frame buffer sink that logs output block writes
// Assumes: one block corner per blk_wr_valid pulse
// Notes: keeps the latest sixteen blocks only, older entries overwritten
`timescale 1ns/1ps
module lce_sdram_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic blk_wr_valid,
  input wire logic [31:0] blk_wr_addr,
  input wire logic [13:0] blk_x,
  input wire logic [13:0] blk_y,
  output logic [31:0] addr_log [0:15],
  output logic [13:0] x_log [0:15],
  output logic [13:0] y_log [0:15],
  output int blk_count
);
  // count is not cleared by runs, so a second frame would show up as extra blocks
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      blk_count <= 0;
    end else if (blk_wr_valid) begin
      addr_log[blk_count[3:0]] <= blk_wr_addr;
      x_log[blk_count[3:0]] <= blk_x;
      y_log[blk_count[3:0]] <= blk_y;
      blk_count <= blk_count + 1;
    end
  end
endmodule

// [verif/lens_correction_control_test.sv]
// Purpose: self-checking bench of the lens correction control shell
// Assumes: one Avalon-MM answer per request, read data valid when waitrequest is low
// Notes: random table data and base address from a fixed-seed lfsr
`timescale 1ns/1ps
`include "lce_regs.svh"
module lens_correction_control_test;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, blk_wr_addr, q, base;
  logic [3:0] avs_byteenable;
  logic cpu_tbl_req, cpu_tbl_we, eng_busy, frame_done_evt, out_route_select, blk_wr_valid;
  logic [9:0] cpu_tbl_addr;
  logic [15:0] cpu_tbl_wdata, cpu_tbl_rdata;
  logic [1:0] func_select;
  logic [13:0] blk_x, blk_y;
  logic [31:0] addr_log [0:15];
  logic [13:0] x_log [0:15];
  logic [13:0] y_log [0:15];
  logic [15:0] tv [0:3];
  logic [15:0] seed = 16'h001A;
  int blk_count;
  int failures = 0;
  int compares = 0;
  int n;

  ////////////////////////////////////////////////////////////////////////////////
  // design and far side
  lce_ctrl_top lce_ctrl_top_inst (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_tbl_req, .cpu_tbl_we, .cpu_tbl_addr, .cpu_tbl_wdata,
    .cpu_tbl_rdata, .eng_busy, .frame_done_evt, .func_select, .out_route_select, .blk_wr_valid, .blk_wr_addr,
    .blk_x, .blk_y);
  lce_sdram_model lce_sdram_model_inst (.ref_clk, .sys_rst, .blk_wr_valid, .blk_wr_addr, .blk_x, .blk_y,
    .addr_log, .x_log, .y_log, .blk_count);

  // free-running 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // corner address of block k in a 2x2 walk of 16x2 blocks, two bytes per pixel
  function automatic logic [31:0] blk_addr(input logic [31:0] b, input int k);
    return b + 32'((k / 2) * 2 * 32'h400 + (k % 2) * 32);
  endfunction

  task automatic stop_test;
    $display("counts: compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus cycle; the extra edge keeps back-to-back drives apart
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      failures++;
      stop_test;
    end
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  task automatic pulse_reset;
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
  endtask

  // bounded wait for the end-of-frame pulse; a hang counts as a mismatch
  task automatic wait_eof;
    n = 0;
    while (frame_done_evt !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 200) begin
      failures++;
      stop_test;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    {cpu_tbl_req, cpu_tbl_we, cpu_tbl_addr, cpu_tbl_wdata} = '0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(`LCE_OFS_CTRL, 32'h0000_0600);
    rd(`LCE_OFS_SRC_BASE, 32'h0000_0000);
    rd(7'h40, 32'h0000_0000);
    $display("test reset done");
    // linear table load through the register port
    wr(`LCE_OFS_TBL_PTR, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      tv[i] = seed;
      wr(`LCE_OFS_TBL_WDATA, {16'h0000, seed});
    end
    rd(`LCE_OFS_TBL_PTR, 32'h0000_0004);
    wr(`LCE_OFS_TBL_PTR, 32'h0000_0000);
    for (int i = 0; i < 4; i++) rd(`LCE_OFS_TBL_RDATA, {16'h0000, tv[i]});
    pulse_reset;
    rd(`LCE_OFS_CTRL, 32'h0000_0600);
    rd(`LCE_OFS_TBL_PTR, 32'h0000_0000);
    wr(`LCE_OFS_TBL_PTR, 32'h0000_0000);
    for (int i = 0; i < 4; i++) rd(`LCE_OFS_TBL_RDATA, {16'h0000, tv[i]});
    $display("test table done");
    // aligned, legal region of 2x2 blocks, all set before the run bit
    seed = lfsr(seed);
    base = {seed, 16'h0000};
    wr(`LCE_OFS_DST_PITCH, 32'h0000_0400);
    wr(`LCE_OFS_DST_BASE, base);
    wr(`LCE_OFS_CHROMA_SRC, 32'h0000_5000);
    wr(`LCE_OFS_CHROMA_DST, 32'h0000_6000);
    wr(`LCE_OFS_REGION_BASE, base);
    wr(`LCE_OFS_BLOCK, 32'h0002_0010);
    wr(`LCE_OFS_REGION_XY, 32'h0004_0020);
    wr(`LCE_OFS_REGION_WH, 32'h0004_0020);
    wr(`LCE_OFS_FRAME_SIZE, 32'h0008_0040);
    wr(`LCE_OFS_SRC_BASE, 32'h0000_1000);
    wr(`LCE_OFS_CTRL, 32'h0000_070D);
    chk(eng_busy, 1);
    chk(func_select, 3);
    chk(out_route_select, 1);
    wr(`LCE_OFS_SRC_BASE, 32'h0000_2000);
    wr(`LCE_OFS_CTRL, 32'h0000_0000);
    chk(eng_busy, 1);
    rd(`LCE_OFS_SRC_BASE, 32'h0000_1000);
    wait_eof;
    chk(eng_busy, 0);
    chk(blk_count, 4);
    for (int k = 0; k < 4; k++) begin
      chk(addr_log[k], blk_addr(base, k));
      chk(x_log[k], 32'(32 + (k % 2) * 16));
      chk(y_log[k], 32'(4 + (k / 2) * 2));
    end
    repeat (40) @(posedge ref_clk);
    chk(blk_count, 4);
    rd(`LCE_OFS_STATUS, 32'h0000_0004);
    rd(`LCE_OFS_CTRL, 32'h0000_070C);
    wr(`LCE_OFS_SRC_BASE, 32'h0000_2000);
    rd(`LCE_OFS_SRC_BASE, 32'h0000_2000);
    rd(`LCE_OFS_CHROMA_DST, 32'h0000_6000);
    $display("test run done");
    // a start with the engine clock gated off is dropped; an empty region ends at once
    wr(`LCE_OFS_CTRL, 32'h0000_0201);
    chk(eng_busy, 0);
    chk(out_route_select, 0);
    rd(`LCE_OFS_CTRL, 32'h0000_0200);
    wr(`LCE_OFS_REGION_WH, 32'h0000_0000);
    wr(`LCE_OFS_CTRL, 32'h0000_0401);
    chk(eng_busy, 1);
    wait_eof;
    chk(eng_busy, 0);
    chk(blk_count, 4);
    rd(`LCE_OFS_STATUS, 32'h0000_0000);
    $display("test corner runs done");
    // processor path owns the table: no register-port stepping
    wr(`LCE_OFS_CTRL, 32'h0000_0400);
    wr(`LCE_OFS_TBL_WDATA, 32'h0000_00A5);
    rd(`LCE_OFS_TBL_PTR, 32'h0000_0004);
    seed = lfsr(seed);
    cpu_tbl_req <= 1'b1;
    cpu_tbl_we <= 1'b1;
    cpu_tbl_addr <= 10'h005;
    cpu_tbl_wdata <= seed;
    @(posedge ref_clk);
    cpu_tbl_we <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(cpu_tbl_rdata, seed);
    cpu_tbl_req <= 1'b0;
    $display("test processor path done");
    // reset after registers were changed must bring them back
    pulse_reset;
    rd(`LCE_OFS_SRC_BASE, 32'h0000_0000);
    rd(`LCE_OFS_CHROMA_DST, 32'h0000_0000);
    rd(`LCE_OFS_TBL_PTR, 32'h0000_0000);
    rd(`LCE_OFS_CTRL, 32'h0000_0600);
    $display("test second reset done");
    stop_test;
  end
endmodule
